// *** bdm_decoder.sv ***
// banked data memory decoder with core registers and register slave
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "bdm_map.svh"
module bdm_decoder (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic core_req,
    input wire logic core_we,
    input wire logic [6:0] core_addr,
    input wire logic [7:0] core_wdata,
    output logic core_ack,
    output logic [7:0] core_rdata,
    output logic periph_sel,
    output logic periph_we,
    output logic [8:0] periph_addr,
    output logic [7:0] periph_wdata,
    input wire logic [7:0] periph_rdata,
    output bdm_pkg::bdm_var_t gpr_variant,
    input wire logic [11:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [11:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);
    import bdm_pkg::*;

    logic [7:0] status;
    logic [7:0] file_select_pointer;
    logic [7:0] pcl;
    logic [4:0] pclath;
    logic [7:0] intcon;
    logic [8:0] last_addr;
    bdm_var_t variant;

    logic aw_got;
    logic w_got;
    logic ar_got;
    logic wr_busy;
    logic rd_busy;
    logic [9:0] aw_idx;
    logic [9:0] ar_idx;
    logic [7:0] w_byte;
    logic w_lane;
    logic ax_pend;
    logic ax_we;
    logic [6:0] ax_off;
    logic [7:0] ax_wd;
    logic ax_done;
    logic [7:0] ax_rdata;
    logic wr_go;
    logic rd_go;

    logic op_v;
    logic op_we;
    logic [6:0] op_off;
    logic [7:0] op_wd;
    logic [8:0] tgt;
    logic [8:0] fold;
    logic [9:0] gmap;
    bdm_cls_t cls;

    logic s1_v;
    logic s1_core;
    bdm_cls_t s1_cls;
    logic [7:0] s1_data;
    logic [7:0] rd_mux;

    bdm_ram_if ram_bus ();

    bdm_gpr_ram u_ram (
        .aclk(aclk),
        .ram(ram_bus)
    );

    // storage index of an address, top bit set when it is implemented
    function automatic logic [9:0] gpr_map(input logic [8:0] a,
                                           input bdm_var_t v);
        logic [8:0] o;
        logic mid;
        o = {2'b00, a[6:0]};
        mid = (a[6:0] >= `BDM_GPR_LO) && (a[6:0] < `BDM_GPR_HI);
        gpr_map = 10'h000;
        case (a[8:7])
            2'b00: begin
                if (a[6:0] >= `BDM_GPR_LO) begin
                    gpr_map = {1'b1, o - {2'b00, `BDM_GPR_LO}};
                end
            end
            2'b01: begin
                if (mid) begin
                    gpr_map = {1'b1, `BDM_B1_BASE + o - {2'b00, `BDM_GPR_LO}};
                end
            end
            2'b10: begin
                if (mid) begin
                    gpr_map = {1'b1, `BDM_B2_BASE + o - {2'b00, `BDM_GPR_LO}};
                end
            end
            default: begin
                if (mid && v != VAR_256) begin
                    gpr_map = {1'b1, `BDM_B3_BASE + o - {2'b00, `BDM_GPR_LO}};
                end else if (v == VAR_352 && a[6:0] >= `BDM_XTRA_LO &&
                             a[6:0] < `BDM_GPR_LO) begin
                    gpr_map = {1'b1, `BDM_XTRA_BASE + o -
                               {2'b00, `BDM_XTRA_LO}};
                end
            end
        endcase
    endfunction

    // what kind of cell answers at a folded address
    function automatic bdm_cls_t classify(input logic [8:0] a,
                                          input bdm_var_t v);
        logic [9:0] g;
        g = gpr_map(a, v);
        if (g[9]) begin
            classify = CLS_GPR;
        end else begin
            case (a[6:0])
                `BDM_OFF_PCL, `BDM_OFF_STATUS, `BDM_OFF_FSR,
                `BDM_OFF_PCLATH, `BDM_OFF_INTCON: classify = CLS_CORE;
                `BDM_OFF_INDIRECT: classify = CLS_NONE;
                default: begin
                    if (a[6:0] < `BDM_GPR_LO) begin
                        classify = CLS_PERIPH;
                    end else begin
                        classify = CLS_NONE;
                    end
                end
            endcase
        end
    endfunction

    function automatic logic idx_mem(input logic [9:0] i);
        idx_mem = (i == `BDM_IDX_INDIRECT) || (i == `BDM_IDX_STATUS) ||
                  (i == `BDM_IDX_FSR);
    endfunction

    // the core has priority; a bus access waits for an idle cycle
    always_comb begin
        op_v = core_req || ax_pend;
        op_we = core_req ? core_we : ax_we;
        op_off = core_req ? core_addr : ax_off;
        op_wd = core_req ? core_wdata : ax_wd;
        if (op_off == `BDM_OFF_INDIRECT) begin
            tgt = {status[`BDM_BIT_INDIRECT_BANK], file_select_pointer};
        end else begin
            tgt = {status[`BDM_BIT_BANK_SEL_HI],
                   status[`BDM_BIT_BANK_SEL_LO], op_off};
        end
        if (tgt[6:0] >= `BDM_WIN_LO) begin
            fold = {2'b00, tgt[6:0]};
        end else begin
            fold = tgt;
        end
        gmap = gpr_map(fold, variant);
        cls = classify(fold, variant);
    end

    assign ram_bus.en = op_v && (cls == CLS_GPR);
    assign ram_bus.we = op_we;
    assign ram_bus.addr = gmap[8:0];
    assign ram_bus.wdata = op_wd;

    // core-owned special registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status <= `BDM_STATUS_RESET;
            file_select_pointer <= 8'h00;
            pcl <= 8'h00;
            pclath <= 5'h00;
            intcon <= 8'h00;
        end else if (op_v && op_we && cls == CLS_CORE) begin
            case (fold[6:0])
                `BDM_OFF_STATUS: begin
                    status <= (op_wd & ~`BDM_STATUS_KEEP) |
                              (status & `BDM_STATUS_KEEP);
                end
                `BDM_OFF_FSR: file_select_pointer <= op_wd;
                `BDM_OFF_PCL: pcl <= op_wd;
                `BDM_OFF_PCLATH: pclath <= op_wd[4:0];
                `BDM_OFF_INTCON: intcon <= op_wd;
                default: pcl <= pcl;
            endcase
        end
    end

    // first stage: capture core register value and peripheral request
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_v <= 1'b0;
            s1_core <= 1'b0;
            s1_cls <= CLS_NONE;
            s1_data <= 8'h00;
            periph_sel <= 1'b0;
            periph_we <= 1'b0;
            periph_addr <= 9'h000;
            periph_wdata <= 8'h00;
            last_addr <= 9'h000;
        end else begin
            s1_v <= op_v;
            s1_core <= core_req;
            s1_cls <= cls;
            case (fold[6:0])
                `BDM_OFF_PCL: s1_data <= pcl;
                `BDM_OFF_STATUS: s1_data <= status;
                `BDM_OFF_FSR: s1_data <= file_select_pointer;
                `BDM_OFF_PCLATH: s1_data <= {3'h0, pclath};
                `BDM_OFF_INTCON: s1_data <= intcon;
                default: s1_data <= 8'h00;
            endcase
            periph_sel <= op_v && (cls == CLS_PERIPH);
            if (op_v) begin
                periph_we <= op_we;
                periph_addr <= fold;
                periph_wdata <= op_wd;
                last_addr <= fold;
            end
        end
    end

    always_comb begin
        case (s1_cls)
            CLS_GPR: rd_mux = ram_bus.rdata;
            CLS_PERIPH: rd_mux = periph_rdata;
            CLS_CORE: rd_mux = s1_data;
            default: rd_mux = 8'h00;
        endcase
    end

    // second stage: answer to the core or to the bus sequencer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            core_ack <= 1'b0;
            core_rdata <= 8'h00;
            ax_done <= 1'b0;
            ax_rdata <= 8'h00;
        end else begin
            core_ack <= s1_v && s1_core;
            ax_done <= s1_v && !s1_core;
            if (s1_v && s1_core) begin
                core_rdata <= rd_mux;
            end
            if (s1_v && !s1_core) begin
                ax_rdata <= rd_mux;
            end
        end
    end

    // bus address and data channels
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b0;
            aw_got <= 1'b0;
            aw_idx <= 10'h000;
            wready <= 1'b0;
            w_got <= 1'b0;
            w_byte <= 8'h00;
            w_lane <= 1'b0;
            arready <= 1'b0;
            ar_got <= 1'b0;
            ar_idx <= 10'h000;
        end else begin
            if (awvalid && awready) begin
                awready <= 1'b0;
                aw_got <= 1'b1;
                aw_idx <= awaddr[11:2];
            end else if (bvalid && bready) begin
                aw_got <= 1'b0;
            end else begin
                awready <= !aw_got;
            end
            if (wvalid && wready) begin
                wready <= 1'b0;
                w_got <= 1'b1;
                w_byte <= wdata[7:0];
                w_lane <= wstrb[0];
            end else if (bvalid && bready) begin
                w_got <= 1'b0;
            end else begin
                wready <= !w_got;
            end
            if (arvalid && arready) begin
                arready <= 1'b0;
                ar_got <= 1'b1;
                ar_idx <= araddr[11:2];
            end else if (rvalid && rready) begin
                ar_got <= 1'b0;
            end else begin
                arready <= !ar_got;
            end
        end
    end

    assign wr_go = aw_got && w_got && !wr_busy && !rd_busy && !ax_pend;
    assign rd_go = ar_got && !rd_busy && !wr_busy && !ax_pend && !wr_go;
    assign gpr_variant = variant;

    // bus sequencer and responses
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_busy <= 1'b0;
            rd_busy <= 1'b0;
            ax_pend <= 1'b0;
            ax_we <= 1'b0;
            ax_off <= 7'h00;
            ax_wd <= 8'h00;
            bvalid <= 1'b0;
            bresp <= `BDM_RESP_OKAY;
            rvalid <= 1'b0;
            rresp <= `BDM_RESP_OKAY;
            rdata <= 32'h0000_0000;
            variant <= VAR_336;
        end else begin
            if (ax_pend && !core_req) begin
                ax_pend <= 1'b0;
            end
            if (wr_go) begin
                wr_busy <= 1'b1;
                ax_we <= 1'b1;
                ax_off <= aw_idx[6:0];
                ax_wd <= w_byte;
                if (idx_mem(aw_idx) && w_lane) begin
                    ax_pend <= 1'b1;
                end else begin
                    bvalid <= 1'b1;
                    bresp <= (idx_mem(aw_idx) || aw_idx == `BDM_IDX_VARIANT ||
                              aw_idx == `BDM_IDX_LAST) ?
                             `BDM_RESP_OKAY : `BDM_RESP_SLVERR;
                    if (aw_idx == `BDM_IDX_VARIANT && w_lane &&
                        w_byte[1:0] != 2'h3) begin
                        variant <= bdm_var_t'(w_byte[1:0]);
                    end
                end
            end
            if (rd_go) begin
                rd_busy <= 1'b1;
                ax_we <= 1'b0;
                ax_off <= ar_idx[6:0];
                if (idx_mem(ar_idx)) begin
                    ax_pend <= 1'b1;
                end else begin
                    rvalid <= 1'b1;
                    rresp <= `BDM_RESP_OKAY;
                    if (ar_idx == `BDM_IDX_VARIANT) begin
                        rdata <= {30'h0, variant};
                    end else if (ar_idx == `BDM_IDX_LAST) begin
                        rdata <= {23'h0, last_addr};
                    end else begin
                        rdata <= 32'h0000_0000;
                        rresp <= `BDM_RESP_SLVERR;
                    end
                end
            end
            if (ax_done && wr_busy) begin
                bvalid <= 1'b1;
                bresp <= `BDM_RESP_OKAY;
            end
            if (ax_done && rd_busy) begin
                rvalid <= 1'b1;
                rresp <= `BDM_RESP_OKAY;
                rdata <= {24'h0, ax_rdata};
            end
            if (bvalid && bready) begin
                bvalid <= 1'b0;
                wr_busy <= 1'b0;
            end
            if (rvalid && rready) begin
                rvalid <= 1'b0;
                rd_busy <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_direct_mid;
        core_req && core_addr >= `BDM_GPR_LO && core_addr < `BDM_WIN_LO;
    endsequence

    sequence s_status_read;
        core_req && !core_we && core_addr == `BDM_OFF_STATUS;
    endsequence

    chk_bank_select: assert property (
        s_direct_mid |=> last_addr == {$past(status[6:5]), $past(core_addr)})
        else $error("direct address not formed from bank bits");

    chk_shared_window: assert property (
        core_req && core_addr >= `BDM_WIN_LO |=> last_addr[8:7] == 2'b00)
        else $error("shared window not folded to bank 0");

    chk_indirect_path: assert property (
        core_req && core_addr == `BDM_OFF_INDIRECT &&
        file_select_pointer[6:0] < `BDM_WIN_LO |=>
        last_addr == {$past(status[7]), $past(file_select_pointer)})
        else $error("indirect access ignored file pointer");

    chk_mirror_status: assert property (
        s_status_read |-> ##2 core_ack && core_rdata == $past(status, 2))
        else $error("status not answered at mirrored offset");

    chk_unimpl_zero: assert property (
        core_req && !core_we && cls == CLS_NONE |-> ##2 core_rdata == 8'h00)
        else $error("unimplemented location read nonzero");

    chk_gpr_depth: assert property (
        op_v && cls == CLS_GPR |-> gmap[8:0] < ((variant == VAR_256) ?
        9'h100 : (variant == VAR_352) ? 9'h160 : 9'h150))
        else $error("storage index beyond variant size");

    chk_bank0_base: assert property (
        op_v && fold == 9'h020 |-> cls == CLS_GPR && gmap[8:0] == 9'h000)
        else $error("bank 0 storage does not start at 20h");

    chk_sfr_route: assert property (
        op_v && cls == CLS_PERIPH |=> periph_sel && periph_addr == $past(fold))
        else $error("special register not routed to peripheral");

    chk_status_bits: assert property (
        core_req && core_we && core_addr == `BDM_OFF_STATUS |=>
        status[6:5] == $past(core_wdata[6:5]) && status[4:3] == $past(status[4:3]))
        else $error("bank bits not written at status 6 and 5");

    chk_core_answer: assert property (
        core_req |-> ##2 core_ack && s1_core == 1'b0 || core_ack)
        else $error("core answer not two cycles after request");
endmodule
`default_nettype wire

// *** bdm_gpr_ram.sv ***
// general storage array, one read or write per cycle
`timescale 1ns/1ns
`default_nettype none
`include "bdm_map.svh"
module bdm_gpr_ram (
    input wire logic aclk,
    bdm_ram_if.mem ram
);
    logic [7:0] cells [0:`BDM_GPR_DEPTH-1];

    always_ff @(posedge aclk) begin
        if (ram.en) begin
            if (ram.we) begin
                cells[ram.addr] <= ram.wdata;
            end
            ram.rdata <= cells[ram.addr];
        end
    end
endmodule
`default_nettype wire

// *** bdm_map.svh ***
// address map, field positions, reset values and sizes of the data memory
`ifndef BDM_MAP_SVH
`define BDM_MAP_SVH

`define BDM_IDX_INDIRECT 10'h000
`define BDM_IDX_STATUS 10'h003
`define BDM_IDX_FSR 10'h004
`define BDM_IDX_VARIANT 10'h008
`define BDM_IDX_LAST 10'h009

`define BDM_OFF_INDIRECT 7'h00
`define BDM_OFF_PCL 7'h02
`define BDM_OFF_STATUS 7'h03
`define BDM_OFF_FSR 7'h04
`define BDM_OFF_PCLATH 7'h0a
`define BDM_OFF_INTCON 7'h0b

`define BDM_BIT_INDIRECT_BANK 7
`define BDM_BIT_BANK_SEL_HI 6
`define BDM_BIT_BANK_SEL_LO 5

`define BDM_STATUS_RESET 8'h18
`define BDM_STATUS_KEEP 8'h18

`define BDM_GPR_LO 7'h20
`define BDM_GPR_HI 7'h70
`define BDM_WIN_LO 7'h70
`define BDM_XTRA_LO 7'h10
`define BDM_B1_BASE 9'h060
`define BDM_B2_BASE 9'h0b0
`define BDM_B3_BASE 9'h100
`define BDM_XTRA_BASE 9'h150
`define BDM_GPR_DEPTH 352

`define BDM_RESP_OKAY 2'h0
`define BDM_RESP_SLVERR 2'h2

`endif

// *** bdm_periph_model.sv ***
// peripheral register responder on the far side of the decoder
`timescale 1ns/1ns
`default_nettype none
module bdm_periph_model (
    input wire logic aclk,
    input wire logic periph_sel,
    input wire logic periph_we,
    input wire logic [8:0] periph_addr,
    input wire logic [7:0] periph_wdata,
    output logic [7:0] periph_rdata
);
    logic [7:0] regs [512];
    logic [7:0] last = 8'h00;
    initial begin
        for (int i = 0; i < 512; i++) begin
            regs[i] = 8'(i) ^ 8'h5a;
        end
    end
    always @(posedge aclk) begin
        if (periph_sel === 1'b1 && periph_we === 1'b1) begin
            regs[periph_addr] <= periph_wdata;
        end
        last <= periph_rdata;
    end
    // idle bus toggles so a stale value never passes as read data
    always_comb begin
        if (periph_sel === 1'b1) begin
            periph_rdata = regs[periph_addr];
        end else begin
            periph_rdata = ~last;
        end
    end
endmodule
`default_nettype wire

// *** bdm_pkg.sv ***
// types shared by the data memory decoder and its testbench
package bdm_pkg;
    typedef enum logic [1:0] {
        CLS_NONE = 2'h0,
        CLS_CORE = 2'h1,
        CLS_GPR = 2'h3,
        CLS_PERIPH = 2'h2
    } bdm_cls_t;

    typedef enum logic [1:0] {
        VAR_256 = 2'h0,
        VAR_352 = 2'h1,
        VAR_336 = 2'h2
    } bdm_var_t;
endpackage

// *** bdm_ram_if.sv ***
// port between the decoder and the general storage array
`timescale 1ns/1ns
`default_nettype none
interface bdm_ram_if;
    logic en;
    logic we;
    logic [8:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport ctl (output en, output we, output addr, output wdata,
                 input rdata);
    modport mem (input en, input we, input addr, input wdata,
                 output rdata);
endinterface
`default_nettype wire

// *** tb_banked_data_memory_decoder.sv ***
// testbench for the banked data memory decoder
`timescale 1ns/1ns
`default_nettype none
`include "bdm_map.svh"
module tb_banked_data_memory_decoder;
    import bdm_pkg::*;
    typedef struct {logic chk; logic [7:0] val; string nm;} bdm_note_t;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic core_req = 1'b0;
    logic core_we = 1'b0;
    logic [6:0] core_addr = 7'h00;
    logic [7:0] core_wdata = 8'h00;
    logic core_ack, periph_sel, periph_we;
    logic [7:0] core_rdata, periph_wdata, periph_rdata;
    logic [8:0] periph_addr;
    bdm_var_t gpr_variant;
    logic [11:0] awaddr = 12'h000;
    logic [11:0] araddr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    bdm_note_t notes[$];
    bdm_note_t cur;
    int bad_count = 0;
    int total_checks = 0;
    int seed = 78;
    logic [31:0] d;
    logic [1:0] r;
    logic [6:0] ra;
    logic [7:0] rv;

    always #5 aclk = ~aclk;

    bdm_decoder dut (.aclk(aclk), .aresetn(aresetn), .core_req(core_req),
        .core_we(core_we), .core_addr(core_addr), .core_wdata(core_wdata),
        .core_ack(core_ack), .core_rdata(core_rdata),
        .periph_sel(periph_sel), .periph_we(periph_we),
        .periph_addr(periph_addr), .periph_wdata(periph_wdata),
        .periph_rdata(periph_rdata), .gpr_variant(gpr_variant),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready));

    bdm_periph_model partner (.aclk(aclk), .periph_sel(periph_sel),
        .periph_we(periph_we), .periph_addr(periph_addr),
        .periph_wdata(periph_wdata), .periph_rdata(periph_rdata));

    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // one core access per cycle, the expected read noted for the watcher
    task automatic op(input logic we, input logic [6:0] a,
                      input logic [7:0] wd, input logic [7:0] ex,
                      input string nm);
        bdm_note_t n;
        @(posedge aclk);
        core_req <= 1'b1;
        core_we <= we;
        core_addr <= a;
        core_wdata <= wd;
        n.chk = !we;
        n.val = ex;
        n.nm = nm;
        notes.push_back(n);
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] wd);
        op(1'b1, a, wd, 8'h00, "write");
    endtask

    task automatic rd(input logic [6:0] a, input logic [7:0] ex,
                      input string nm);
        op(1'b0, a, 8'h00, ex, nm);
    endtask

    task automatic drain();
        @(posedge aclk);
        core_req <= 1'b0;
        while (notes.size() != 0) begin
            @(posedge aclk);
        end
        @(posedge aclk);
    endtask

    task automatic set_bank(input logic [1:0] b, input logic ib);
        wr(`BDM_OFF_STATUS, {ib, b, 5'h00});
        drain();
    endtask

    task automatic axi_wr(input logic [11:0] a, input logic [31:0] wd,
                          output logic [1:0] resp);
        @(posedge aclk);
        awaddr <= a;
        wdata <= wd;
        wstrb <= 4'h1;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (awvalid === 1'b1 && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid === 1'b1 && wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        resp = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [11:0] a, output logic [31:0] rd_d,
                          output logic [1:0] resp);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arvalid === 1'b1 && arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        rd_d = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask

    // read data is taken in the one cycle that core_ack stands
    always @(posedge aclk) begin
        if (aresetn === 1'b1 && core_ack === 1'b1) begin
            if (notes.size() == 0) begin
                bad_count++;
                $display("BAD core_ack expected none seen pulse");
            end else begin
                cur = notes.pop_front();
                if (cur.chk) check(cur.nm, {24'h0, core_rdata}, {24'h0, cur.val});
            end
        end
    end

    initial begin
        repeat (20000) @(posedge aclk);
        bad_count++;
        $display("BAD watchdog expected finish seen hang");
        complete_run();
    end

    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`BDM_OFF_STATUS, `BDM_STATUS_RESET, "status reset");
        drain();
        axi_rd(12'h020, d, r);
        check("variant reset", d, 32'h2);
        $display("test reset done");
        for (int b = 0; b < 4; b++) begin
            set_bank(b[1:0], 1'b0);
            rd(`BDM_OFF_STATUS, {1'b0, b[1:0], 5'h18}, "status bank");
            wr(7'h20, 8'ha0 + 8'(b));
            wr(7'h6f, 8'hb0 + 8'(b));
            drain();
        end
        set_bank(2'h3, 1'b0);
        wr(7'h70, 8'h5a);
        set_bank(2'h1, 1'b0);
        wr(7'h7f, 8'hc3);
        set_bank(2'h2, 1'b0);
        wr(`BDM_OFF_FSR, 8'h33);
        wr(`BDM_OFF_PCLATH, 8'hff);
        wr(`BDM_OFF_INTCON, 8'ha5);
        drain();
        for (int b = 0; b < 4; b++) begin
            set_bank(b[1:0], 1'b0);
            rd(7'h20, 8'ha0 + 8'(b), "bank lowest storage");
            rd(7'h6f, 8'hb0 + 8'(b), "bank top storage");
            rd(7'h70, 8'h5a, "shared window low");
            rd(7'h7f, 8'hc3, "shared window high");
            rd(`BDM_OFF_FSR, 8'h33, "mirror pointer");
            rd(`BDM_OFF_PCLATH, 8'h1f, "mirror pclath");
            rd(`BDM_OFF_INTCON, 8'ha5, "mirror intcon");
            drain();
        end
        $display("test banks done");
        set_bank(2'h0, 1'b0);
        wr(`BDM_OFF_FSR, 8'ha1);
        wr(`BDM_OFF_INDIRECT, 8'h77);
        rd(`BDM_OFF_INDIRECT, 8'h77, "indirect bank1");
        wr(`BDM_OFF_FSR, 8'h85);
        wr(`BDM_OFF_INDIRECT, 8'h9e);
        wr(`BDM_OFF_FSR, 8'h00);
        rd(`BDM_OFF_INDIRECT, 8'h00, "indirect of zero");
        drain();
        set_bank(2'h0, 1'b1);
        wr(`BDM_OFF_FSR, 8'h22);
        wr(`BDM_OFF_INDIRECT, 8'h66);
        drain();
        set_bank(2'h1, 1'b0);
        rd(7'h21, 8'h77, "direct after indirect");
        rd(7'h05, 8'h9e, "peripheral register");
        drain();
        set_bank(2'h2, 1'b0);
        rd(7'h22, 8'h66, "indirect bank bit");
        drain();
        $display("test indirect done");
        axi_wr(12'h020, 32'h0, r);
        check("variant write resp", {30'h0, r}, {30'h0, `BDM_RESP_OKAY});
        check("variant 256", {30'h0, gpr_variant}, {30'h0, VAR_256});
        set_bank(2'h3, 1'b0);
        wr(7'h30, 8'hff);
        rd(7'h30, 8'h00, "unimplemented reads zero");
        drain();
        axi_wr(12'h020, 32'h1, r);
        wr(7'h10, 8'h3c);
        rd(7'h10, 8'h3c, "variant 352 extra");
        drain();
        axi_wr(12'h020, 32'h2, r);
        wr(7'h30, 8'hc1);
        rd(7'h30, 8'hc1, "variant 336 bank3");
        drain();
        axi_rd(12'h024, d, r);
        check("last folded address", d, 32'h1b0);
        axi_rd(12'h00c, d, r);
        check("status over bus", d, 32'h78);
        axi_rd(12'h040, d, r);
        check("unmapped read data", d, 32'h0);
        check("unmapped read resp", {30'h0, r}, {30'h0, `BDM_RESP_SLVERR});
        axi_wr(12'h040, 32'hff, r);
        check("unmapped write", {30'h0, r}, {30'h0, `BDM_RESP_SLVERR});
        $display("test register bus done");
        set_bank(2'h0, 1'b0);
        for (int i = 0; i < 8; i++) begin
            ra = 7'(32'h20 + ($unsigned($random(seed)) % 80));
            rv = 8'($random(seed));
            wr(ra, rv);
            rd(ra, rv, "random storage");
        end
        drain();
        $display("test random done");
        complete_run();
    end
endmodule
`default_nettype wire
